// ### design/csa_alu.sv
// Four-bit ALU: add, subtract via two's complement, logic, rotates.
// Purely combinational; the caller registers results and flags.
`timescale 1ns/10ps
`default_nettype none
module csa_alu (
  input wire csa_pkg::csa_op_type op,
  input wire logic [3:0] opa,
  input wire logic [3:0] opb,
  input wire logic carry_in,
  output logic [3:0] result,
  output logic carry_out,
  output logic zero_out
);
  import csa_pkg::*;
  logic [4:0] sum;
  // Operation select
  always_comb
  begin
    sum = 5'h00;
    result = opb;
    carry_out = carry_in;
    case (op)
      OP_ADD:
      begin
        sum = {1'b0, opa} + {1'b0, opb}; // RULE_14
        result = sum[3:0];
        carry_out = sum[4];
      end
      OP_ADD_WITH_CARRY:
      begin
        sum = {1'b0, opa} + {1'b0, opb} + {4'h0, carry_in}; // RULE_17
        result = sum[3:0];
        carry_out = sum[4];
      end
      OP_SUB, OP_CMP:
      begin
        sum = {1'b0, opa} + {1'b0, ~opb} + 5'h01; // RULE_14
        result = sum[3:0];
        carry_out = sum[4];
      end
      OP_SUBC:
      begin
        sum = {1'b0, opa} + {1'b0, ~opb} + {4'h0, carry_in}; // RULE_17
        result = sum[3:0];
        carry_out = sum[4];
      end
      OP_AND: result = opa & opb;
      OP_OR: result = opa | opb;
      OP_XOR: result = opa ^ opb;
      OP_ROTATE_LEFT_THROUGH_CARRY:
      begin
        result = {opa[2:0], carry_in}; // RULE_15
        carry_out = opa[3];
      end
      OP_ROTATE_RIGHT_THROUGH_CARRY:
      begin
        result = {carry_in, opa[3:1]}; // RULE_15
        carry_out = opa[0];
      end
      default: result = opb;
    endcase
  end
  // Zero detect
  assign zero_out = (result == ZERO_NIB); // RULE_16
endmodule : csa_alu
`default_nettype wire

// ### design/csa_core.sv
// Stack, stack location pointer, table pointer and data memory with ALU/flags.
// Assumes a sequencer that holds call/return requests until done pulses.
// Notes on behaviour
// RULE_01: A call saves only the return address; subroutine return restores it.
// RULE_02: Interrupt entry saves address and flags; interrupt return restores both.
// RULE_03: Up to fifteen stack locations in data memory, four words each.
// RULE_04: Pointer drops after a save, rises before a restore.
// RULE_05: Stack location pointer lives in the top data memory word.
// RULE_06: Pointer can never name location fifteen; normal range zero to twelve; code does not exclude fifteen.
// RULE_07: Hardware never initialises the pointer; software writes it, usually twelve.
// RULE_08: Locations thirteen and fourteen share storage with timer counts.
// RULE_09: Twelve-bit table pointer is three memory nibbles at 7c, 7d, 7e.
// RULE_10: Timer counts sit in memory nibbles; 77 and 7b stay free.
// RULE_11: Zero-page forms reach the first sixteen words.
// RULE_12: Data memory is not cleared; its content starts undefined.
// RULE_13: ALU takes four-bit operands, gives result, carry and zero.
// RULE_14: Add carry is top carry-out; subtract carry means no borrow.
// RULE_15: Rotates through carry shift old carry in, shifted-out bit out.
// RULE_16: Zero indication is one when result or transferred value is zero.
// RULE_17: Add and subtract with carry use and then capture carry.
// RULE_18: Compare captures the non-borrow carry.
// RULE_19: Carry tests copy carry, or its inverse, then set or clear carry.
// RULE_20: Zero flag loads on operate, rotate, input and load to accumulator.
// RULE_21: Branch is taken only while the branch-condition bit is one.
// RULE_22: Reset sets the branch-condition bit, other flags untouched.
`timescale 1ns/10ps
`default_nettype none
module csa_core (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic small_variant,
  input wire csa_pkg::csa_op_type op,
  input wire logic [3:0] acc_in,
  input wire logic [6:0] mem_addr,
  input wire logic zero_page,
  input wire logic mem_wr,
  input wire logic [3:0] mem_wdata,
  input wire logic table_advance,
  input wire logic branch_req,
  input wire logic call_req,
  input wire logic intr_req,
  input wire logic ret_req,
  input wire logic interrupt_return_req,
  input wire logic [10:0] pc_in,
  output logic [3:0] mem_rdata,
  output logic [3:0] alu_result,
  output logic [11:0] table_lookup_pointer,
  output logic [3:0] stack_location_pointer,
  output logic [10:0] pc_restored,
  output logic stack_done,
  output logic branch_taken,
  output logic carry_bit,
  output logic zero_result_bit,
  output logic branch_condition_bit,
  output logic general_purpose_bit
);
  import csa_pkg::*;
  // Storage, uncleared at power-on
  logic [3:0] ram [0:127]; // RULE_12
  logic [10:0] pc_q = 11'h000;
  csa_stk_state_type state;
  csa_stk_kind_type kind;
  logic [1:0] word_idx;
  logic [3:0] slp_work;
  logic [3:0] res_wire;
  logic alu_c;
  logic alu_z;
  logic restore_en;
  logic [3:0] restore_val;
  logic [6:0] eff_addr;
  logic [6:0] slp_addr;
  logic [6:0] stk_addr;
  logic [3:0] stk_wdata;
  logic [3:0] flag_nib;

  // Address of word w in stack location n
  function automatic logic [6:0] loc_addr(input logic [3:0] n, input logic [1:0] w);
    loc_addr = STACK_BASE + {1'b0, n, w}; // RULE_03
  endfunction : loc_addr

  // Pointer address by variant
  assign slp_addr = small_variant ? ADDR_SLP_SMALL : ADDR_SLP_BIG; // RULE_05
  // Zero page forms replace the three page bits
  assign eff_addr = zero_page ? {ZERO_PAGE_HI[2:0], mem_addr[3:0]} : mem_addr; // RULE_11

  csa_alu u_alu (
    .op(op),
    .opa(acc_in),
    .opb(mem_rdata),
    .carry_in(carry_bit),
    .result(res_wire),
    .carry_out(alu_c),
    .zero_out(alu_z)
  );

  csa_flags u_flags (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .op(op),
    .alu_carry(alu_c),
    .alu_zero(alu_z),
    .restore_en(restore_en),
    .restore_val(restore_val),
    .carry_bit(carry_bit),
    .zero_result_bit(zero_result_bit),
    .branch_condition_bit(branch_condition_bit),
    .general_purpose_bit(general_purpose_bit)
  );

  assign alu_result = res_wire; // RULE_13
  assign branch_taken = branch_req & branch_condition_bit; // RULE_21
  assign flag_nib = {carry_bit, zero_result_bit, branch_condition_bit, general_purpose_bit};
  assign mem_rdata = ram[eff_addr];

  // Table pointer read out of its three nibbles
  assign table_lookup_pointer = {ram[ADDR_TBL_HIGH], ram[ADDR_TBL_MID],
                                 ram[ADDR_TBL_LOW]}; // RULE_09
  // Stack pointer read from the top word as stored; location fifteen is not excluded
  assign stack_location_pointer = ram[slp_addr]; // RULE_06

  // Word written while saving: pc nibbles then flags, or zero for a call
  always_comb
  begin
    case (word_idx)
      2'h0: stk_wdata = pc_q[3:0];
      2'h1: stk_wdata = pc_q[7:4];
      2'h2: stk_wdata = {1'b0, pc_q[10:8]};
      default: stk_wdata = (kind == STK_INTR) ? flag_nib : ZERO_NIB; // RULE_02
    endcase
  end
  assign stk_addr = loc_addr(slp_work, word_idx);
  assign restore_en = (state == ST_POP) && (kind == STK_INTR) &&
                      (word_idx == WORDS_PER_LOC); // RULE_02
  assign restore_val = ram[stk_addr];

  // Save and restore sequencer
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      kind <= STK_NONE;
      word_idx <= 2'h0;
      slp_work <= 4'h0;
      stack_done <= 1'b0;
    end
    else
    begin
      stack_done <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          word_idx <= 2'h0;
          slp_work <= ram[slp_addr];
          if (call_req | intr_req)
          begin
            kind <= intr_req ? STK_INTR : STK_CALL; // RULE_01
            state <= ST_PUSH;
          end
          else if (ret_req | interrupt_return_req)
          begin
            kind <= interrupt_return_req ? STK_INTR : STK_CALL;
            slp_work <= ram[slp_addr] + 4'h1; // RULE_04
            state <= ST_POP;
          end
        end
        ST_PUSH:
        begin
          word_idx <= word_idx + 2'h1;
          if (word_idx == WORDS_PER_LOC)
            state <= ST_DONE;
        end
        ST_POP:
        begin
          word_idx <= word_idx + 2'h1;
          if (word_idx == WORDS_PER_LOC)
            state <= ST_DONE;
        end
        ST_DONE:
        begin
          stack_done <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Return address: captured when a save starts, assembled during a restore
  always_ff @(posedge clk_sys)
  begin
    if (state == ST_IDLE && (call_req | intr_req))
      pc_q <= pc_in;
    else if (state == ST_POP)
      case (word_idx)
        2'h0: pc_q[3:0] <= ram[stk_addr]; // RULE_01
        2'h1: pc_q[7:4] <= ram[stk_addr];
        2'h2: pc_q[10:8] <= ram[stk_addr][2:0];
        default: pc_q <= pc_q;
      endcase
  end
  assign pc_restored = pc_q;

  // Data memory writes: stack, pointer, table advance, ordinary stores
  always_ff @(posedge clk_sys)
  begin
    if (state == ST_PUSH)
    begin
      ram[stk_addr] <= stk_wdata; // RULE_08
      if (word_idx == WORDS_PER_LOC)
        ram[slp_addr] <= slp_work - 4'h1; // RULE_04
    end
    else if (state == ST_POP && word_idx == WORDS_PER_LOC)
      ram[slp_addr] <= slp_work; // RULE_04
    else if (table_advance)
      {ram[ADDR_TBL_HIGH], ram[ADDR_TBL_MID], ram[ADDR_TBL_LOW]} <=
        table_lookup_pointer + 12'h001; // RULE_09
    else if (mem_wr)
      ram[eff_addr] <= mem_wdata; // RULE_10
  end
endmodule : csa_core
`default_nettype wire

// ### design/csa_flags.sv
// Carry, zero, branch-condition and general flags.
// Assumes the sequencer gives one op per cycle and a restore strobe.
`timescale 1ns/10ps
`default_nettype none
module csa_flags (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire csa_pkg::csa_op_type op,
  input wire logic alu_carry,
  input wire logic alu_zero,
  input wire logic restore_en,
  input wire logic [3:0] restore_val,
  output logic carry_bit,
  output logic zero_result_bit,
  output logic branch_condition_bit,
  output logic general_purpose_bit
);
  import csa_pkg::*;
  logic carry_q = 1'b0;
  logic zero_q = 1'b0;
  logic gen_q = 1'b0;
  assign carry_bit = carry_q;
  assign zero_result_bit = zero_q;
  assign general_purpose_bit = gen_q;
  // Carry flag; no reset term
  always_ff @(posedge clk_sys)
  begin
    if (restore_en)
      carry_q <= restore_val[3]; // RULE_02
    else
      case (op)
        OP_ADD_WITH_CARRY, OP_SUBC: carry_q <= alu_carry; // RULE_17
        OP_CMP: carry_q <= alu_carry; // RULE_18
        OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY: carry_q <= alu_carry; // RULE_15
        OP_TESTP_C: carry_q <= 1'b1; // RULE_19
        OP_TEST_C: carry_q <= 1'b0; // RULE_19
        default: carry_q <= carry_q;
      endcase
  end
  // Zero flag; no reset term
  always_ff @(posedge clk_sys)
  begin
    if (restore_en)
      zero_q <= restore_val[2]; // RULE_02
    else
      case (op)
        OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUBC, OP_CMP, OP_AND, OP_OR, OP_XOR,
        OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY, OP_LOAD: zero_q <= alu_zero; // RULE_20
        default: zero_q <= zero_q;
      endcase
  end
  // General flag
  always_ff @(posedge clk_sys)
  begin
    if (restore_en)
      gen_q <= restore_val[0];
    else if (op == OP_SET_G)
      gen_q <= 1'b1;
    else if (op == OP_CLR_G)
      gen_q <= 1'b0;
  end
  // Branch-condition flag; only flag touched by reset
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      branch_condition_bit <= 1'b1; // RULE_22
    else if (restore_en)
      branch_condition_bit <= restore_val[1]; // RULE_02
    else
      case (op)
        OP_TESTP_C: branch_condition_bit <= carry_q; // RULE_19
        OP_TEST_C: branch_condition_bit <= ~carry_q; // RULE_19
        OP_CMP: branch_condition_bit <= ~alu_zero;
        OP_CLR_BC: branch_condition_bit <= 1'b0;
        default: branch_condition_bit <= 1'b1; // RULE_21
      endcase
  end
endmodule : csa_flags
`default_nettype wire

// ### design/csa_pkg.sv
// Shared constants and types for the stack, pointer, ALU and flag datapath.
// Assumes a sequencer that issues one operation code per cycle.
package csa_pkg;
  localparam int ADDR_W = 7;
  localparam int PC_W = 11;
  localparam int NIB_W = 4;
  localparam logic [6:0] ADDR_TBL_LOW = 7'h7c;
  localparam logic [6:0] ADDR_TBL_MID = 7'h7d;
  localparam logic [6:0] ADDR_TBL_HIGH = 7'h7e;
  localparam logic [6:0] ADDR_SLP_BIG = 7'h7f;
  localparam logic [6:0] ADDR_SLP_SMALL = 7'h3f;
  localparam logic [6:0] ADDR_SPARE_A = 7'h77;
  localparam logic [6:0] ADDR_SPARE_B = 7'h7b;
  localparam logic [6:0] STACK_BASE = 7'h40;
  localparam logic [3:0] SLP_TOP = 4'he;
  localparam logic [3:0] SLP_NORMAL_TOP = 4'hc;
  localparam logic [3:0] SLP_TIMER_ONE = 4'hd;
  localparam logic [3:0] SLP_TIMER_TWO = 4'he;
  localparam logic [3:0] ZERO_NIB = 4'h0;
  localparam logic [3:0] ZERO_PAGE_HI = 4'h0;
  localparam logic [1:0] WORDS_PER_LOC = 2'h3;
  typedef enum logic [4:0] {
    OP_NONE = 5'h00, OP_ADD = 5'h01, OP_ADD_WITH_CARRY = 5'h02, OP_SUB = 5'h03,
    OP_SUBC = 5'h04, OP_CMP = 5'h05, OP_AND = 5'h06, OP_OR = 5'h07,
    OP_XOR = 5'h08, OP_ROTATE_LEFT_THROUGH_CARRY = 5'h09, OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h0a, OP_LOAD = 5'h0b,
    OP_TESTP_C = 5'h0c, OP_TEST_C = 5'h0d, OP_SET_BC = 5'h0e, OP_CLR_BC = 5'h0f,
    OP_SET_G = 5'h10, OP_CLR_G = 5'h11, OP_STORE = 5'h12
  } csa_op_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_PUSH = 3'b001, ST_POP = 3'b011, ST_DONE = 3'b010
  } csa_stk_state_type;
  typedef enum logic [1:0] {
    STK_NONE = 2'h0, STK_CALL = 2'h1, STK_INTR = 2'h2
  } csa_stk_kind_type;
endpackage : csa_pkg

// ### tb/csa_core_properties.sv
// Port-level checks of the stack, ALU and flag core.
// Assumes the operand b of the ALU is the memory read word.
`timescale 1ns/10ps
`default_nettype none
module csa_core_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire csa_pkg::csa_op_type op,
  input wire logic [3:0] acc_in,
  input wire logic [3:0] mem_rdata,
  input wire logic branch_req,
  input wire logic call_req,
  input wire logic ret_req,
  input wire logic [3:0] alu_result,
  input wire logic [3:0] stack_location_pointer,
  input wire logic stack_done,
  input wire logic branch_taken,
  input wire logic carry_bit,
  input wire logic zero_result_bit,
  input wire logic branch_condition_bit
);
  import csa_pkg::*;
  logic add_with_carry_co;
  logic acc_top;
  // Expected carry-out and rotate bit
  assign add_with_carry_co = ({1'b0, acc_in} + {1'b0, mem_rdata} + carry_bit) > 5'd15;
  assign acc_top = acc_in[3];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_call;
    $rose(call_req);
  endsequence
  sequence s_ret;
    $rose(ret_req);
  endsequence
  AST_BRANCH: assert property (branch_taken == (branch_req && branch_condition_bit))
    else $error("branch taken mismatch");
  AST_TESTP: assert property (op == OP_TESTP_C |=> carry_bit && branch_condition_bit == $past(carry_bit))
    else $error("carry test set wrong");
  AST_TESTC: assert property (op == OP_TEST_C |=> !carry_bit && branch_condition_bit == !$past(carry_bit))
    else $error("carry test clear wrong");
  AST_ZERO: assert property ((op == OP_ADD || op == OP_AND) |=> zero_result_bit == ($past(alu_result) == 4'h0))
    else $error("zero flag wrong");
  AST_ADD_WITH_CARRY: assert property (op == OP_ADD_WITH_CARRY |-> alu_result == acc_in + mem_rdata + carry_bit ##1 carry_bit == $past(add_with_carry_co))
    else $error("add with carry wrong");
  AST_ROTATE_LEFT_THROUGH_CARRY: assert property (op == OP_ROTATE_LEFT_THROUGH_CARRY |-> alu_result == {acc_in[2:0], carry_bit} ##1 carry_bit == $past(acc_top))
    else $error("rotate left wrong");
  AST_PUSH: assert property (s_call |-> ##6 stack_done && stack_location_pointer == $past(stack_location_pointer, 6) - 4'h1)
    else $error("push pointer wrong");
  AST_POP: assert property (s_ret |-> ##6 stack_done && stack_location_pointer == $past(stack_location_pointer, 6) + 4'h1)
    else $error("pop pointer wrong");
  AST_DONE: assert property (stack_done |=> !stack_done)
    else $error("done longer than one cycle");
  AST_RESET: assert property ($rose(arst_n) |-> branch_condition_bit)
    else $error("branch bit not set by reset");
endmodule : csa_core_chk
bind csa_core csa_core_chk u_chk (.*);
`default_nettype wire

// ### tb/csa_seq_model.sv
// Sequencer stand-in that raises one stack request and holds it.
// Assumes go and kind come from the bench on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module csa_seq_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic stack_done,
  output var logic call_req,
  output var logic intr_req,
  output var logic ret_req,
  output var logic interrupt_return_req
);
  logic [3:0] req = 4'h0;
  logic go_s = 1'b0;
  logic [1:0] kind_s = 2'h0;
  // Capture a start order
  always @(posedge clk_sys)
  begin
    go_s <= go;
    kind_s <= kind;
  end
  // Raise the request, drop it once done shows
  always @(negedge clk_sys)
  begin
    if (stack_done)
      req <= 4'h0;
    else if (go_s)
      req[kind_s] <= 1'b1;
  end
  assign {interrupt_return_req, ret_req, intr_req, call_req} = req;
endmodule : csa_seq_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the stack, pointer, ALU and flag core.
// Assumes the sequencer model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import csa_pkg::*;
  logic clk_sys = 0;
  logic arst_n = 0;
  logic small_variant = 0;
  csa_op_type op = OP_NONE;
  logic [3:0] acc_in = 4'h0;
  logic [6:0] mem_addr = 7'h00;
  logic zero_page = 0;
  logic mem_wr = 0;
  logic [3:0] mem_wdata = 4'h0;
  logic table_advance = 0;
  logic branch_req = 1;
  logic go = 0;
  logic [1:0] kind = 2'h0;
  logic [10:0] pc_in = 11'h000;
  logic call_req, intr_req, ret_req, interrupt_return_req, stack_done, branch_taken;
  logic carry_bit, zero_result_bit, branch_condition_bit, general_purpose_bit;
  logic [3:0] mem_rdata, alu_result, stack_location_pointer;
  logic [11:0] table_lookup_pointer;
  logic [10:0] pc_restored;
  int err_count = 0;
  int n_tests = 0;
  csa_core DUT (.*);
  csa_seq_model u_seq (.clk_sys(clk_sys), .go(go), .kind(kind), .stack_done(stack_done),
    .call_req(call_req), .intr_req(intr_req), .ret_req(ret_req), .interrupt_return_req(interrupt_return_req));
  always #50 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1;
    @(negedge clk_sys);
    mem_wr = 0;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [3:0] d);
    mem_addr = a;
    #1 chk("mem", {8'h0, d}, {8'h0, mem_rdata});
  endtask : rd
  task automatic fop(input csa_op_type o);
    op = o;
    @(negedge clk_sys);
    op = OP_NONE;
  endtask : fop
  task automatic alu(input csa_op_type o, input logic [3:0] a, input logic [3:0] r);
    acc_in = a;
    op = o;
    #1 chk("alu", {8'h0, r}, {8'h0, alu_result});
    fop(o);
  endtask : alu
  task automatic stk(input logic [1:0] k);
    int i;
    kind = k;
    go = 1;
    @(negedge clk_sys);
    go = 0;
    for (i = 0; i < 20 && stack_done !== 1'b1; i++) @(negedge clk_sys);
    chk("done", 12'h1, {11'h0, stack_done});
    @(negedge clk_sys);
  endtask : stk
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Watchdog against a hung handshake
  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    repeat (3) @(negedge clk_sys);
    arst_n = 1;
    @(negedge clk_sys);
    chk("bc", 12'h1, {11'h0, branch_condition_bit});
    small_variant = 1;
    wr(7'h3f, 4'h9);
    chk("slp", 12'h9, {8'h0, stack_location_pointer});
    small_variant = 0;
    wr(7'h7f, 4'hc);
    chk("slp", 12'hc, {8'h0, stack_location_pointer});
    wr(7'h7c, 4'h0);
    wr(7'h7d, 4'h8);
    wr(7'h7e, 4'h3);
    chk("tlp", 12'h380, table_lookup_pointer);
    table_advance = 1;
    @(negedge clk_sys);
    table_advance = 0;
    rd(7'h7c, 4'h1);
    wr(7'h77, 4'h6);
    rd(7'h77, 4'h6);
    wr(7'h05, 4'h5);
    zero_page = 1;
    rd(7'h35, 4'h5);
    zero_page = 0;
    rd(7'h05, 4'h5);
    alu(OP_ADD, 4'hb, 4'h0);
    chk("z", 12'h1, {11'h0, zero_result_bit});
    alu(OP_ADD, 4'h4, 4'h9);
    chk("z", 12'h0, {11'h0, zero_result_bit});
    alu(OP_CMP, 4'h5, 4'h0);
    chk("c", 12'h1, {11'h0, carry_bit});
    fop(OP_TESTP_C);
    chk("c bc bt", 12'h7, {9'h0, carry_bit, branch_condition_bit, branch_taken});
    fop(OP_TEST_C);
    chk("c bc bt", 12'h0, {9'h0, carry_bit, branch_condition_bit, branch_taken});
    alu(OP_ADD_WITH_CARRY, 4'hb, 4'h0);
    chk("c z", 12'h3, {10'h0, carry_bit, zero_result_bit});
    alu(OP_ADD_WITH_CARRY, 4'hb, 4'h1);
    chk("c z", 12'h2, {10'h0, carry_bit, zero_result_bit});
    fop(OP_TEST_C);
    alu(OP_SUBC, 4'h5, 4'hf);
    chk("c z", 12'h0, {10'h0, carry_bit, zero_result_bit});
    fop(OP_TESTP_C);
    alu(OP_SUBC, 4'h5, 4'h0);
    chk("c z", 12'h3, {10'h0, carry_bit, zero_result_bit});
    alu(OP_ROTATE_LEFT_THROUGH_CARRY, 4'hc, 4'h9);
    chk("c z", 12'h2, {10'h0, carry_bit, zero_result_bit});
    alu(OP_ROTATE_RIGHT_THROUGH_CARRY, 4'h2, 4'h9);
    chk("c z", 12'h0, {10'h0, carry_bit, zero_result_bit});
    pc_in = 11'h5a3;
    stk(2'h0);
    chk("slp", 12'hb, {8'h0, stack_location_pointer});
    rd(7'h70, 4'h3);
    rd(7'h71, 4'ha);
    rd(7'h72, 4'h5);
    rd(7'h73, 4'h0);
    fop(OP_SET_G);
    pc_in = 11'h123;
    stk(2'h1);
    rd(7'h6c, 4'h3);
    rd(7'h6e, 4'h1);
    rd(7'h6f, 4'h3);
    fop(OP_TESTP_C);
    fop(OP_CLR_G);
    stk(2'h3);
    chk("pc", {1'b0, 11'h123}, {1'b0, pc_restored});
    chk("c g slp", 12'h1b, {6'h0, carry_bit, general_purpose_bit, stack_location_pointer});
    stk(2'h2);
    chk("pc", {1'b0, 11'h5a3}, {1'b0, pc_restored});
    chk("slp", 12'hc, {8'h0, stack_location_pointer});
    wr(7'h06, 4'h0);
    rd(7'h06, 4'h0);
    alu(OP_LOAD, 4'h7, 4'h0);
    chk("z", 12'h1, {11'h0, zero_result_bit});
    wr(7'h7f, 4'hd);
    stk(2'h0);
    rd(7'h74, 4'h3);
    rd(7'h77, 4'h0);
    chk("slp", 12'hc, {8'h0, stack_location_pointer});
    fop(OP_TESTP_C);
    fop(OP_TEST_C);
    arst_n = 0;
    @(negedge clk_sys);
    arst_n = 1;
    #1 chk("c bc g", 12'h3, {9'h0, carry_bit, branch_condition_bit, general_purpose_bit});
    chk("slp", 12'hc, {8'h0, stack_location_pointer});
    @(negedge clk_sys);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
